// >>> xte_exec.sv
// Purpose: Executes direction-load, literal xor and file xor instructions.
// Assumes: One instruction presented per enabled cycle; file registers held here.
// Notes:   All results land one clock after the instruction is presented.
module xte_exec (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Instruction
   input  wire logic [11:0] insn,
   input  wire logic        insn_valid,
   // Accumulator preload
   input  wire logic        acc_load,
   input  wire logic [7:0]  acc_load_data,
   // File register preload
   input  wire logic        file_load,
   input  wire logic [4:0]  file_load_adr,
   input  wire logic [7:0]  file_load_data,
   // File read port
   input  wire logic [4:0]  file_rd_adr,
   output logic      [7:0]  file_rd_data,
   // State outputs
   output logic      [7:0]  acc,
   output logic      [7:0]  dir_a,
   output logic      [7:0]  dir_b,
   output logic             zero_flag,
   output logic             done
);
   typedef struct packed {
      logic [31:0][7:0] files;
      logic [7:0]       acc;
      logic [7:0]       dir_a;
      logic [7:0]       dir_b;
      logic             zero;
      logic             done;
      logic [7:0]       rd_data;
   } xte_state_s;

   xte_state_s st_ff;
   xte_state_s nxt_st;
   xte_dec_if  dec_bus ();

   // Instruction decoder.
   xte_decode u_dec (
      .insn       (insn),
      .insn_valid (insn_valid),
      .dec        (dec_bus.dec)
   );

   // Next-state computation for all instructions and preloads.
   always_comb
   begin
      logic [7:0] res;
      res = 8'h00;
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (acc_load)
      begin
         nxt_st.acc = acc_load_data;
      end
      if (file_load)
      begin
         nxt_st.files[file_load_adr] = file_load_data;
      end
      if (dec_bus.is_dir)
      begin
         if (dec_bus.dir_sel == xte_pkg::DIR_SEL_LO)
         begin
            nxt_st.dir_a = st_ff.acc;
         end
         else if (dec_bus.dir_sel == xte_pkg::DIR_SEL_HI)
         begin
            nxt_st.dir_b = st_ff.acc;
         end
         nxt_st.done = 1'b1;
      end
      else if (dec_bus.is_xlit)
      begin
         res = st_ff.acc ^ dec_bus.literal;
         nxt_st.acc = res;
         nxt_st.zero = (res == 8'h00);
         nxt_st.done = 1'b1;
      end
      else if (dec_bus.is_xfil)
      begin
         res = st_ff.acc ^ st_ff.files[dec_bus.fadr];
         if (dec_bus.dest)
         begin
            nxt_st.files[dec_bus.fadr] = res;
         end
         else
         begin
            nxt_st.acc = res;
         end
         nxt_st.zero = (res == 8'h00);
         nxt_st.done = 1'b1;
      end
      nxt_st.rd_data = nxt_st.files[file_rd_adr];
   end

   // State register with synchronous reset and clock enable.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_ff.files   <= {xte_pkg::NUM_FILES{xte_pkg::FILE_RST}};
         st_ff.acc     <= xte_pkg::ACC_RST;
         st_ff.dir_a   <= xte_pkg::DIR_RST;
         st_ff.dir_b   <= xte_pkg::DIR_RST;
         st_ff.zero    <= 1'b0;
         st_ff.done    <= 1'b0;
         st_ff.rd_data <= xte_pkg::FILE_RST;
      end
      else if (clk_en)
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register.
   assign acc          = st_ff.acc;
   assign dir_a        = st_ff.dir_a;
   assign dir_b        = st_ff.dir_b;
   assign zero_flag    = st_ff.zero;
   assign done         = st_ff.done;
   assign file_rd_data = st_ff.rd_data;
endmodule : xte_exec

// >>> xte_pkg.sv
// Purpose: Shared constants for the xor and direction-load execution block.
// Assumes: 12-bit instruction words, 8-bit data path, 5-bit file addresses.
// Notes:   Opcode patterns are matched against masked instruction words.
package xte_pkg;
   localparam int unsigned INSN_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FADR_W = 5;
   localparam int unsigned DIR_SEL_W = 3;
   // Direction-load: nine zero bits then a 3-bit selector.
   localparam logic [11:0] DIR_MASK = 12'hff8;
   localparam logic [11:0] DIR_CODE = 12'h000;
   localparam logic [2:0] DIR_SEL_LO = 3'h6;
   localparam logic [2:0] DIR_SEL_HI = 3'h7;
   // Literal xor: top nibble all ones.
   localparam logic [11:0] XLIT_MASK = 12'hf00;
   localparam logic [11:0] XLIT_CODE = 12'hf00;
   // File xor: 6-bit opcode 000110.
   localparam logic [11:0] XFIL_MASK = 12'hfc0;
   localparam logic [11:0] XFIL_CODE = 12'h180;
   // Field positions.
   localparam int unsigned DEST_BIT = 5;
   // Reset values.
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [7:0] FILE_RST = 8'h00;
   localparam int unsigned NUM_FILES = 32;
endpackage : xte_pkg

// >>> xte_dec_if.sv
// Purpose: Carries decoded instruction fields from the decoder to the executor.
// Assumes: Single clock domain; signals are combinational.
// Notes:   One strobe per instruction kind.
interface xte_dec_if;
   logic       is_dir;
   logic       is_xlit;
   logic       is_xfil;
   logic [2:0] dir_sel;
   logic [7:0] literal;
   logic [4:0] fadr;
   logic       dest;
   modport dec (output is_dir, is_xlit, is_xfil, dir_sel, literal, fadr, dest);
   modport exe (input is_dir, is_xlit, is_xfil, dir_sel, literal, fadr, dest);
endinterface : xte_dec_if

// >>> xte_decode.sv
// Purpose: Decodes the three supported instruction words into fields.
// Assumes: Instruction word is stable while insn_valid is high.
// Notes:   Unsupported words raise no strobe.
module xte_decode (
   // Instruction
   input wire logic [11:0] insn,
   input wire logic        insn_valid,
   // Decoded fields
   xte_dec_if.dec          dec
);
   // Returns true when the masked word matches the pattern.
   function automatic logic op_match(input logic [11:0] w, input logic [11:0] m, input logic [11:0] c);
      op_match = ((w & m) == c);
   endfunction : op_match

   // Field extraction and pattern matching.
   assign dec.is_dir  = insn_valid && op_match(insn, xte_pkg::DIR_MASK, xte_pkg::DIR_CODE);
   assign dec.is_xlit = insn_valid && op_match(insn, xte_pkg::XLIT_MASK, xte_pkg::XLIT_CODE);
   assign dec.is_xfil = insn_valid && op_match(insn, xte_pkg::XFIL_MASK, xte_pkg::XFIL_CODE);
   assign dec.dir_sel = insn[2:0];
   assign dec.literal = insn[7:0];
   assign dec.fadr    = insn[4:0];
   assign dec.dest    = insn[xte_pkg::DEST_BIT];
endmodule : xte_decode

// >>> xte_exec_properties.sv
// Purpose: Checks the execution results of the xor and direction-load block.
// Assumes: One clock domain with a synchronous reset.
// Notes:   Attached to the executor by bind.
module xte_exec_props (
   // Clock, reset and instruction
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire logic [11:0] insn,
   input wire logic        insn_valid,
   input wire logic        acc_load,
   // Results
   input wire logic [7:0]  acc,
   input wire logic [7:0]  dir_a,
   input wire logic [7:0]  dir_b,
   input wire logic        zero_flag,
   input wire logic        done
);
   timeunit 1ns;
   timeprecision 1ps;
   // Instruction taken at this edge, by kind.
   wire logic go = clk_en & ~rst & insn_valid;
   wire logic dl = go & (insn[11:3] == 9'h000);
   wire logic xl = go & (insn[11:8] == 4'hf);
   wire logic xf = go & (insn[11:6] == 6'h06);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   dir_copy_a: assert property (dl & insn[2:1] == 2'h3 |=> ($past(insn[0]) ? dir_b : dir_a) == $past(acc))
      else $error("direction register not loaded from accumulator");
   dir_sel_a: assert property (dl & insn[2:1] != 2'h3 |=> $stable(dir_a) & $stable(dir_b) & done)
      else $error("direction register changed by other selector");
   xlit_acc_a: assert property (xl |=> acc == ($past(acc) ^ $past(insn[7:0])) & done)
      else $error("literal xor result wrong");
   xfil_acc_a: assert property (xf & ~insn[5] |=> zero_flag == (acc == 8'h00) & done)
      else $error("file xor to accumulator wrong");
   xfil_file_a: assert property (xf & insn[5] & ~acc_load |=> $stable(acc) & done)
      else $error("file xor changed accumulator");
   dir_zero_a: assert property (dl |=> $stable(zero_flag) & done)
      else $error("direction load touched zero flag");
   cover property (dl);
   cover property (xl ##1 xf);
   cover property (xf & insn[5]);
endmodule : xte_exec_props

bind xte_exec xte_exec_props xte_exec_props_inst (.core_clk, .rst, .clk_en, .insn, .insn_valid, .acc_load,
   .acc, .dir_a, .dir_b, .zero_flag, .done);

// >>> tb_xor_and_direction_load_instruction_exec.sv
// Purpose: Self-checking bench for the xor and direction-load executor.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   File register 3 is used throughout.
module tb_xor_and_direction_load_instruction_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rst = 1, clk_en = 1, insn_valid = 0, acc_load = 0, file_load = 0, zero_flag, done;
   logic [11:0] insn = '0;
   logic [7:0]  acc_load_data = '0, file_load_data = '0, file_rd_data, acc, dir_a, dir_b;
   logic [4:0]  file_load_adr = 5'h03, file_rd_adr = 5'h03;
   int          errors = 0, comparisons = 0;
   xte_exec xte_exec_inst (.core_clk, .rst, .clk_en, .insn, .insn_valid, .acc_load, .acc_load_data, .file_load,
      .file_load_adr, .file_load_data, .file_rd_adr, .file_rd_data, .acc, .dir_a, .dir_b, .zero_flag, .done);
   // Compares one value and reports a mismatch.
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Presents one instruction for one edge and checks the completion pulse.
   task run(input logic [11:0] i);
      @(posedge core_clk) #1 insn = i;
      insn_valid = 1;
      @(posedge core_clk) #1 insn_valid = 0;
      chk("done", 8'h01, {7'h00, done});
   endtask : run
   // Preloads the accumulator and file register 3 together.
   task pre(input logic [7:0] a, input logic [7:0] f);
      @(posedge core_clk) #1 acc_load_data = a;
      file_load_data = f;
      {acc_load, file_load} = 2'h3;
      @(posedge core_clk) #1 {acc_load, file_load} = 2'h0;
   endtask : pre
   task t_xlit;
      pre(8'hb5, 8'haf);
      run(12'hfaf);
      chk("acc", 8'h1a, acc);
      run(12'hf1a);
      chk("zero", 8'h01, {7'h00, zero_flag});
   endtask : t_xlit
   task t_dir;
      chk("dir_a", 8'hff, dir_a);
      pre(8'ha5, 8'haf);
      run(12'h006);
      chk("dir_a", 8'ha5, dir_a);
      run(12'h007);
      chk("dir_b", 8'ha5, dir_b);
      pre(8'h3c, 8'haf);
      run(12'h005);
      chk("dir_a", 8'ha5, dir_a);
      chk("zero", 8'h01, {7'h00, zero_flag});
   endtask : t_dir
   task t_xfil;
      pre(8'hb5, 8'haf);
      run(12'h1a3);
      chk("file", 8'h1a, file_rd_data);
      chk("acc", 8'hb5, acc);
      run(12'h183);
      chk("acc", 8'haf, acc);
      chk("file", 8'h1a, file_rd_data);
      chk("zero", 8'h00, {7'h00, zero_flag});
   endtask : t_xfil
   // Unmatched word, frozen clock enable and a reset in mid-run.
   task t_misc;
      pre(8'h5a, 8'h77);
      @(posedge core_clk) #1 insn = 12'h800;
      insn_valid = 1;
      @(posedge core_clk) #1 insn_valid = 0;
      chk("done", 8'h00, {7'h00, done});
      chk("acc", 8'h5a, acc);
      @(posedge core_clk) #1 clk_en = 0;
      insn = 12'hfff;
      insn_valid = 1;
      @(posedge core_clk) #1 insn_valid = 0;
      clk_en = 1;
      chk("acc", 8'h5a, acc);
      chk("done", 8'h00, {7'h00, done});
      @(posedge core_clk) #1 rst = 1;
      @(posedge core_clk) #1 rst = 0;
      chk("acc", 8'h00, acc);
      chk("dir_a", 8'hff, dir_a);
      chk("dir_b", 8'hff, dir_b);
      chk("file", 8'h00, file_rd_data);
      chk("zero", 8'h00, {7'h00, zero_flag});
   endtask : t_misc
   // Prints the counts and the verdict, then ends the run.
   task test_done;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   // Clock at 50 MHz.
   initial
   begin
      forever #10 core_clk = ~core_clk;
   end
   // Watchdog far beyond the few dozen cycles the tests need.
   initial
   begin
      #10us errors++;
      test_done;
   end
   // Main sequence.
   initial
   begin
      repeat (10) @(posedge core_clk);
      #1 rst = 0;
      t_xlit;
      t_dir;
      t_xfil;
      t_misc;
      test_done;
   end
endmodule : tb_xor_and_direction_load_instruction_exec
